//--- verilog/can_mode_defines.vh
// constants for the can mode control and interrupt priority block
`ifndef CAN_MODE_DEFINES_VH
`define CAN_MODE_DEFINES_VH
`define MODE_NORMAL      3'h0
`define MODE_DISABLED    3'h1
`define MODE_LOOPBACK    3'h2
`define MODE_LISTEN      3'h3
`define MODE_CONFIG      3'h4
`define MODE_ERR_RECOG   3'h7
`define ADDR_TXB2_CON    12'hF20
`define ADDR_TXB1_CON    12'hF30
`define ADDR_TXB0_CON    12'hF40
`define ADDR_RXB1_CON    12'hF50
`define ADDR_RXB0_CON    12'hF60
`define ADDR_STAT0       12'hF6E
`define ADDR_CTRL        12'hF6F
`define ADDR_BTC1        12'hF70
`define ADDR_BTC2        12'hF71
`define ADDR_BTC3        12'hF72
`define ADDR_PIN_IO      12'hF73
`define ADDR_COMMUNICATION_STATUS     12'hF74
`define ADDR_RXERR       12'hF75
`define ADDR_TXERR       12'hF76
`define ADDR_PRIO        12'hF77
`define ADDR_IRQ_STAT    12'hF78
`define ADDR_IRQ_MASK    12'hF79
`define ADDR_BANK15_BASE 12'hF00
`define ACCESS_LOW_BASE  12'hF60
`define CTRL_RESET       8'h80
`define PRIO_RESET       8'h00
`define TXREQ_BIT        3
`define RXM_HI           6
`define RXM_LO           5
`define PRIO_IRX         7
`define PRIO_WAK         6
`define PRIO_ERR         5
`define PRIO_TXB2        4
`define IDLE_BITS        4'hB
`endif

//--- verilog/can_mode_control_irq_priority.v
// can mode request/acknowledge, interrupt priority and register map
`timescale 1ns/1ns
`include "can_mode_defines.vh"
module can_mode_control_irq_priority
#(
  parameter BIT_CYCLES = 250
)
(
  // clock and reset
  input  wire        i_sys_clk,
  input  wire        i_rstn,
  // register port
  input  wire [11:0] i_addr,
  input  wire [7:0]  i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  input  wire        i_bank15_sel,
  output reg  [7:0]  o_rdata,
  // protocol engine side
  input  wire        i_can_rx,
  input  wire        i_tx_busy,
  input  wire        i_rx_busy,
  input  wire        i_tx_done,
  input  wire [7:0]  i_irq_src,
  input  wire [7:0]  i_err_rx,
  input  wire [7:0]  i_err_tx,
  // mode and interrupt outputs
  output reg  [2:0]  o_op_mode,
  output reg         o_irq_high,
  output reg         o_irq_low,
  output reg         o_irq
);

  reg  [7:0]  ctrl_reg;
  reg  [2:0]  mode_reg;
  reg  [7:0]  prio_reg;
  reg  [7:0]  irq_stat_reg;
  reg  [7:0]  irq_mask_reg;
  reg  [7:0]  txcon_reg [0:2];
  reg  [7:0]  rxcon_reg [0:1];
  reg  [7:0]  btc_reg   [0:2];
  reg  [7:0]  pin_io_reg;
  reg  [7:0]  communication_status_reg;
  reg  [15:0] bit_cnt_reg;
  reg  [3:0]  idle_cnt_reg;
  reg         dis_wait_reg;
  reg         rx_s1_reg;
  reg         rx_s2_reg;
  reg         txb_s1_reg;
  reg         txb_s2_reg;
  reg         rxb_s1_reg;
  reg         rxb_s2_reg;
  reg  [7:0]  rdata_next;
  reg  [2:0]  mode_next;
  wire [2:0]  mode_request;
  wire        tx_pending;
  wire        bus_idle;
  wire        err_recog;
  wire        addr_ok;
  wire        wr_ok;
  wire [7:0]  status_value;
  wire [7:0]  irq_pend;

  function is_status_mirror;
    input [11:0] a;
    begin
      is_status_mirror = (a[3:0] == 4'hE) && (a[11:4] >= 8'hF2) && (a[11:4] <= 8'hF6);
    end
  endfunction

  // receive-mode bits 11 ask for error recognition
  function rxm_error;
    input [7:0] c;
    begin
      rxm_error = (c[`RXM_HI:`RXM_LO] == 2'h3);
    end
  endfunction

  function in_access_low;
    input [11:0] a;
    begin
      in_access_low = (a >= `ACCESS_LOW_BASE);
    end
  endfunction

  assign mode_request = ctrl_reg[7:5];
  assign tx_pending   = txcon_reg[0][`TXREQ_BIT] | txcon_reg[1][`TXREQ_BIT] |
                        txcon_reg[2][`TXREQ_BIT] | txb_s2_reg;
  assign bus_idle     = (idle_cnt_reg == `IDLE_BITS);
  assign err_recog    = rxm_error(rxcon_reg[0]) ||
                        rxm_error(rxcon_reg[1]);
  assign status_value = {mode_reg, 5'h00};
  assign addr_ok      = i_bank15_sel | in_access_low(i_addr);
  assign wr_ok        = i_wr & addr_ok;
  assign irq_pend     = irq_stat_reg & irq_mask_reg;

  // bus level is asynchronous; resets recessive so no false activity
  always @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      rx_s1_reg <= 1'b1;
      rx_s2_reg <= 1'b1;
    end
    else
    begin
      rx_s1_reg <= i_can_rx;
      rx_s2_reg <= rx_s1_reg;
    end
  end

  // engine busy levels come from another domain
  always @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      txb_s1_reg <= 1'b0;
      txb_s2_reg <= 1'b0;
      rxb_s1_reg <= 1'b0;
      rxb_s2_reg <= 1'b0;
    end
    else
    begin
      txb_s1_reg <= i_tx_busy;
      txb_s2_reg <= txb_s1_reg;
      rxb_s1_reg <= i_rx_busy;
      rxb_s2_reg <= rxb_s1_reg;
    end
  end

  always @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      bit_cnt_reg  <= 16'h0000;
      idle_cnt_reg <= 4'h0;
    end
    else if (!rx_s2_reg)
    begin
      bit_cnt_reg  <= 16'h0000;
      idle_cnt_reg <= 4'h0;
    end
    else if (bit_cnt_reg == BIT_CYCLES[15:0] - 16'h0001)
    begin
      bit_cnt_reg <= 16'h0000;
      if (!bus_idle)
        idle_cnt_reg <= idle_cnt_reg + 4'h1;
    end
    else
      bit_cnt_reg <= bit_cnt_reg + 16'h0001;
  end

  // disable asked while active keeps waiting for an idle bus
  // even after busy drops, so a frame tail is never cut
  always @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      dis_wait_reg <= 1'b0;
    else if (mode_request != `MODE_DISABLED || mode_reg == `MODE_DISABLED)
      dis_wait_reg <= 1'b0;
    else if (txb_s2_reg | rxb_s2_reg)
      dis_wait_reg <= 1'b1;
  end

  // mode switching
  always @*
  begin
    mode_next = mode_reg;
    if (err_recog && mode_request == `MODE_NORMAL)
    begin
      // error recognition also waits for pending sends
      if (!tx_pending)
        mode_next = `MODE_ERR_RECOG;
    end
    else if (mode_request != mode_reg)
    begin
      case (mode_request)
        `MODE_CONFIG:
          if (!tx_pending)
            mode_next = `MODE_CONFIG;
        `MODE_DISABLED:
          if (!tx_pending && !rxb_s2_reg && (!dis_wait_reg || bus_idle))
            mode_next = `MODE_DISABLED;
        `MODE_NORMAL, `MODE_LOOPBACK, `MODE_LISTEN:
          if (!tx_pending)
            mode_next = mode_request;
        // error recognition cannot be asked for here
        `MODE_ERR_RECOG:
          mode_next = mode_reg;
        default:
          mode_next = mode_reg;
      endcase
    end
  end

  // registers
  always @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      ctrl_reg     <= `CTRL_RESET;
      mode_reg     <= `MODE_CONFIG;
      prio_reg     <= `PRIO_RESET;
      irq_mask_reg <= 8'h00;
      communication_status_reg  <= 8'h00;
      rxcon_reg[0] <= 8'h00;
      rxcon_reg[1] <= 8'h00;
    end
    else
    begin
      mode_reg <= mode_next;
      if (wr_ok)
      begin
        case (i_addr)
          `ADDR_CTRL:
            ctrl_reg <= i_wdata;
          `ADDR_PRIO:
            prio_reg <= i_wdata;
          `ADDR_IRQ_MASK:
            irq_mask_reg <= i_wdata;
          `ADDR_RXB0_CON:
            rxcon_reg[0] <= i_wdata;
          `ADDR_RXB1_CON:
            rxcon_reg[1] <= i_wdata;
          `ADDR_COMMUNICATION_STATUS:
            communication_status_reg <= i_wdata;
          default:
            ctrl_reg <= ctrl_reg;
        endcase
      end
    end
  end

  // a buffer stays pending until the engine reports a frame sent, which clears all three
  // a same-cycle write wins so software can re-arm at once
  always @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      txcon_reg[0] <= 8'h00;
      txcon_reg[1] <= 8'h00;
      txcon_reg[2] <= 8'h00;
    end
    else
    begin
      if (i_tx_done)
      begin
        txcon_reg[0][`TXREQ_BIT] <= 1'b0;
        txcon_reg[1][`TXREQ_BIT] <= 1'b0;
        txcon_reg[2][`TXREQ_BIT] <= 1'b0;
      end
      if (wr_ok && i_addr == `ADDR_TXB0_CON)
        txcon_reg[0] <= i_wdata;
      if (wr_ok && i_addr == `ADDR_TXB1_CON)
        txcon_reg[1] <= i_wdata;
      if (wr_ok && i_addr == `ADDR_TXB2_CON)
        txcon_reg[2] <= i_wdata;
    end
  end

  // timing and pin setup only change in configuration,
  // so a running node never sees its bit timing move
  always @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      btc_reg[0] <= 8'h00;
      btc_reg[1] <= 8'h00;
      btc_reg[2] <= 8'h00;
      pin_io_reg <= 8'h00;
    end
    else if (wr_ok && mode_reg == `MODE_CONFIG)
    begin
      case (i_addr)
        `ADDR_BTC1:
          btc_reg[0] <= i_wdata;
        `ADDR_BTC2:
          btc_reg[1] <= i_wdata;
        `ADDR_BTC3:
          btc_reg[2] <= i_wdata;
        `ADDR_PIN_IO:
          pin_io_reg <= i_wdata;
        default:
          pin_io_reg <= pin_io_reg;
      endcase
    end
  end

  // set wins over write-one-to-clear so no event is lost
  always @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      irq_stat_reg <= 8'h00;
    else if (wr_ok && i_addr == `ADDR_IRQ_STAT)
      irq_stat_reg <= (irq_stat_reg & ~i_wdata) | i_irq_src;
    else
      irq_stat_reg <= irq_stat_reg | i_irq_src;
  end

  // read mux
  always @*
  begin
    rdata_next = 8'h00;
    if (i_rd && addr_ok)
    begin
      // status decoded first so every mirror shows one value
      if (is_status_mirror(i_addr))
        rdata_next = status_value;
      else
        case (i_addr)
          `ADDR_CTRL:
            rdata_next = ctrl_reg;
          `ADDR_PRIO:
            rdata_next = prio_reg;
          `ADDR_IRQ_STAT:
            rdata_next = irq_stat_reg;
          `ADDR_IRQ_MASK:
            rdata_next = irq_mask_reg;
          `ADDR_TXB0_CON:
            rdata_next = txcon_reg[0];
          `ADDR_TXB1_CON:
            rdata_next = txcon_reg[1];
          `ADDR_TXB2_CON:
            rdata_next = txcon_reg[2];
          `ADDR_RXB0_CON:
            rdata_next = rxcon_reg[0];
          `ADDR_RXB1_CON:
            rdata_next = rxcon_reg[1];
          `ADDR_BTC1:
            rdata_next = btc_reg[0];
          `ADDR_BTC2:
            rdata_next = btc_reg[1];
          `ADDR_BTC3:
            rdata_next = btc_reg[2];
          `ADDR_PIN_IO:
            rdata_next = pin_io_reg;
          `ADDR_COMMUNICATION_STATUS:
            rdata_next = communication_status_reg;
          `ADDR_RXERR:
            rdata_next = i_err_rx;
          `ADDR_TXERR:
            rdata_next = i_err_tx;
          default:
            rdata_next = 8'h00;
        endcase
    end
  end

  // outputs
  always @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_rdata    <= 8'h00;
      o_op_mode  <= `MODE_CONFIG;
      o_irq_high <= 1'b0;
      o_irq_low  <= 1'b0;
      o_irq      <= 1'b0;
    end
    else
    begin
      o_rdata    <= rdata_next;
      o_op_mode  <= mode_reg;
      o_irq_high <= |(irq_pend & prio_reg);
      o_irq_low  <= |(irq_pend & ~prio_reg);
      o_irq      <= |irq_pend;
    end
  end

endmodule

//--- test/can_mode_checker.sv
// assertions for the can mode control and interrupt priority block
`timescale 1ns/1ns
module can_mode_checker
(
  // clock, reset and register port
  input wire logic        i_sys_clk, i_rstn, i_rd, i_bank15_sel,
  input wire logic [11:0] i_addr,
  input wire logic [7:0]  i_err_rx, o_rdata,
  // bus side and outputs
  input wire logic        i_can_rx, i_tx_busy, o_irq_high, o_irq_low, o_irq,
  input wire logic [2:0]  o_op_mode
);
  default clocking @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rstn);
  wire mirror_rd = i_rd && i_bank15_sel && i_addr[11:8] == 4'hF && i_addr[3:0] == 4'hE
    && i_addr[7:4] >= 4'h2 && i_addr[7:4] <= 4'h6;
  chk_read_quiet: assert property (!i_rd |=> o_rdata == 8'h00)
    else $error("read data not zero outside a read");
  chk_status_read: assert property (i_rd && i_addr == 12'hF6E ##1 $stable(o_op_mode)
    |-> o_rdata == {o_op_mode, 5'h00}) else $error("status does not show the mode");
  chk_mirror_same: assert property (mirror_rd ##1 $stable(o_op_mode)
    |-> o_rdata == {o_op_mode, 5'h00}) else $error("status mirror differs");
  chk_bank_refuse: assert property (i_rd && !i_bank15_sel && i_addr < 12'hF60
    |=> o_rdata == 8'h00) else $error("bank 15 read without bank select");
  chk_err_count: assert property (i_rd && i_addr == 12'hF75 |=> o_rdata == $past(i_err_rx))
    else $error("receive error count read wrong");
  // mode may only move once the synced busy has dropped
  chk_mode_hold: assert property (i_tx_busy [*6] |=> $stable(o_op_mode))
    else $error("mode changed during transmission");
  chk_no_config: assert property (i_tx_busy [*7] |-> o_op_mode != 3'h4 || $past(o_op_mode) == 3'h4)
    else $error("config entered during transmission");
  chk_disable_idle: assert property ($changed(o_op_mode) && o_op_mode == 3'h1
    |-> $past(i_can_rx, 1) && $past(i_can_rx, 8)) else $error("disabled on busy bus");
  chk_irq_split: assert property (o_irq == (o_irq_high || o_irq_low))
    else $error("irq not the union of both levels");
  cover property (o_op_mode == 3'h7);
  cover property ($rose(o_irq_high));
  cover property (i_tx_busy [*6]);
endmodule
bind can_mode_control_irq_priority can_mode_checker chk (.*);

//--- test/can_node_model.sv
// model of the other nodes driving the shared can bus level
`timescale 1ns/1ns
module can_node_model
(
  input  wire logic i_sys_clk,
  input  wire logic i_active,
  output reg        o_can_level
);
  reg [1:0] phase_reg = 2'h0;
  initial o_can_level = 1'b1;
  // traffic toggles the level; an idle bus is driven recessive by the model
  always @(posedge i_sys_clk)
  begin
    phase_reg <= phase_reg + 2'h1;
    o_can_level <= i_active ? phase_reg[1] : 1'b1;
  end
endmodule

//--- test/testbench.sv
// self-checking bench for the can mode control and interrupt priority block
`timescale 1ns/1ns
module testbench;
  localparam [17:0] MODE_SEQ = {3'h0, 3'h3, 3'h2, 3'h1, 3'h4, 3'h0};
  localparam [7:0]  PRIO = 8'h50;
  reg        i_sys_clk = 1'b0, i_rstn = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_bank15_sel = 1'b1;
  reg        i_tx_busy = 1'b0, i_rx_busy = 1'b0, i_tx_done = 1'b0, bus_active = 1'b0;
  reg [11:0] i_addr = 12'h000;
  reg [7:0]  i_wdata = 8'h00, i_irq_src = 8'h00, i_err_rx = 8'h3C, i_err_tx = 8'hC3, d;
  wire       i_can_rx, o_irq_high, o_irq_low, o_irq;
  wire [7:0] o_rdata;
  wire [2:0] o_op_mode;
  integer    n_mismatch = 0, checks = 0, cyc = 0, i;
  can_mode_control_irq_priority #(.BIT_CYCLES(4)) dut (.*);
  can_node_model node (.i_sys_clk(i_sys_clk), .i_active(bus_active), .o_can_level(i_can_rx));
  initial forever #2 i_sys_clk = ~i_sys_clk;
  task print_verdict;
  begin
    if (n_mismatch == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask
  always @(posedge i_sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch = n_mismatch + 1;
      print_verdict;
    end
  end
  task chk(input [8*12-1:0] name, input [7:0] exp, input [7:0] got);
  begin
    checks = checks + 1;
    if (got !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("CHECK FAILED %0s expected %h seen %h", name, exp, got);
    end
  end
  endtask
  task wr(input [11:0] a, input [7:0] v);
  begin
    @(posedge i_sys_clk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  end
  endtask
  task rc(input [11:0] a, input [7:0] exp);
  begin
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    @(negedge i_sys_clk);
    d = o_rdata;
    chk("register", exp, d);
  end
  endtask
  // software polls status before relying on the new mode
  task wait_mode(input [2:0] m);
    integer k;
  begin
    d = 8'hFF;
    for (k = 0; k < 80 && d !== {m, 5'h00}; k = k + 1)
    begin
      @(posedge i_sys_clk);
      i_addr <= 12'hF6E;
      i_rd <= 1'b1;
      @(posedge i_sys_clk);
      i_rd <= 1'b0;
      @(negedge i_sys_clk);
      d = o_rdata;
    end
    chk("mode status", {m, 5'h00}, d);
    chk("mode output", {5'h00, m}, {5'h00, o_op_mode});
  end
  endtask
  task pulse(input [7:0] s);
  begin
    @(posedge i_sys_clk);
    i_irq_src <= s;
    @(posedge i_sys_clk);
    i_irq_src <= 8'h00;
    repeat (4) @(negedge i_sys_clk);
  end
  endtask
  initial
  begin
    repeat (6) @(posedge i_sys_clk);
    i_rstn <= 1'b1;
    rc(12'hF6E, 8'h80);
    rc(12'hF77, 8'h00);
    rc(12'hF75, 8'h3C);
    rc(12'hF76, 8'hC3);
    rc(12'hF7A, 8'h00);
    wr(12'hF70, 8'h5A);
    rc(12'hF70, 8'h5A);
    for (i = 2; i < 7; i = i + 1)
      rc({4'hF, i[3:0], 4'hE}, 8'h80);
    @(posedge i_sys_clk) i_bank15_sel <= 1'b0;
    rc(12'hF5E, 8'h00);
    rc(12'hF6E, 8'h80);
    @(posedge i_sys_clk) i_bank15_sel <= 1'b1;
    for (i = 0; i < 6; i = i + 1)
    begin
      wr(12'hF6F, {MODE_SEQ[3*i +: 3], 5'h00});
      wait_mode(MODE_SEQ[3*i +: 3]);
    end
    wr(12'hF70, 8'hA5);
    rc(12'hF70, 8'h5A);
    wr(12'hF60, 8'h60);
    wait_mode(3'h7);
    wr(12'hF60, 8'h00);
    wait_mode(3'h0);
    wr(12'hF40, 8'h08);
    @(posedge i_sys_clk) i_tx_busy <= 1'b1;
    wr(12'hF6F, 8'h80);
    repeat (20) @(negedge i_sys_clk);
    chk("held busy", 8'h00, {5'h00, o_op_mode});
    @(posedge i_sys_clk) i_tx_busy <= 1'b0;
    repeat (10) @(negedge i_sys_clk);
    chk("held txreq", 8'h00, {5'h00, o_op_mode});
    @(posedge i_sys_clk) i_tx_done <= 1'b1;
    @(posedge i_sys_clk) i_tx_done <= 1'b0;
    rc(12'hF40, 8'h00);
    wait_mode(3'h4);
    wr(12'hF6F, 8'h00);
    wait_mode(3'h0);
    @(posedge i_sys_clk);
    i_rx_busy <= 1'b1;
    bus_active <= 1'b1;
    wr(12'hF6F, 8'h20);
    repeat (40) @(negedge i_sys_clk);
    chk("dis active", 8'h00, {5'h00, o_op_mode});
    @(posedge i_sys_clk);
    i_rx_busy <= 1'b0;
    bus_active <= 1'b0;
    repeat (36) @(negedge i_sys_clk);
    chk("dis early", 8'h00, {5'h00, o_op_mode});
    wait_mode(3'h1);
    wr(12'hF6F, 8'h00);
    wait_mode(3'h0);
    wr(12'hF79, 8'hFF);
    wr(12'hF77, PRIO);
    rc(12'hF77, PRIO);
    for (i = 0; i < 8; i = i + 1)
    begin
      pulse(8'h01 << i);
      chk("irq high", {7'h00, PRIO[i]}, {7'h00, o_irq_high});
      chk("irq low", {7'h00, ~PRIO[i]}, {7'h00, o_irq_low});
      wr(12'hF78, 8'h01 << i);
      repeat (3) @(negedge i_sys_clk);
      chk("irq clear", 8'h00, {7'h00, o_irq});
    end
    wr(12'hF79, 8'h00);
    pulse(8'h02);
    chk("irq masked", 8'h00, {7'h00, o_irq});
    rc(12'hF78, 8'h02);
    wr(12'hF78, 8'h02);
    rc(12'hF78, 8'h00);
    print_verdict;
  end
endmodule
